// file: hdl/ifsr_flag_regs.sv
`timescale 1ns/100ps
`default_nettype none
module ifsr_flag_regs
  import ifsr_pkg::*;
#(
  parameter int EXT_INPUTS = EXT_INT_COUNT
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEnable,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic sfrRead,
  input wire logic [7:0] sfrWriteData,
  output logic [7:0] sfrReadData,
  input wire logic transferBusyInterrupt,
  input wire logic rtcTick,
  input wire logic flashWriteWhileBusy,
  input wire logic flashWriteAtPassStart,
  input wire logic pushbuttonPressed,
  input wire logic autowakeTimerWake,
  input wire logic pllRise,
  input wire logic pllFall,
  input wire logic [EXT_INPUTS-1:0] externalInterrupts,
  output logic watchdogKick
);
  // ****************************************
  // event flags
  // ****************************************
  logic [FLAG_COUNT-1:0] eventFlag_q;
  logic [FLAG_COUNT-1:0] eventSet;
  logic flagWrite;
  logic statusWrite;

  // the status byte has room for exactly seven live inputs below the kick bit
  generate
    if (EXT_INPUTS != EXT_INT_COUNT) begin : g_bad_width
      $error("external input count must be seven");
    end
  endgenerate

  assign eventSet = {pllFall, pllRise, autowakeTimerWake, pushbuttonPressed,
                     flashWriteAtPassStart, flashWriteWhileBusy, rtcTick,
                     transferBusyInterrupt};
  assign flagWrite = sfrWrite && (sfrAddr == EVENT_FLAG_ADDR);
  assign statusWrite = sfrWrite && (sfrAddr == INT_STATUS_ADDR);

  // one generate loop: each bit sets on its event, clears on a written zero;
  // set beats clear so an event in the clearing cycle is kept
  genvar gi;
  generate
    for (gi = 0; gi < FLAG_COUNT; gi++) begin : g_flag
      always_ff @(posedge clk) begin
        if (reset) begin
          eventFlag_q[gi] <= EVENT_FLAG_RESET[gi];
        end else if (clkEnable) begin
          if (eventSet[gi]) begin
            eventFlag_q[gi] <= 1'b1;
          end else if (flagWrite && !sfrWriteData[gi]) begin
            eventFlag_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // watchdog kick
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      watchdogKick <= 1'b0;
    end else if (clkEnable) begin
      watchdogKick <= statusWrite && sfrWriteData[KICK_BIT];
    end
  end

  // ****************************************
  // read data
  // ****************************************
  // registered read: data appears the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      sfrReadData <= 8'h00;
    end else if (clkEnable) begin
      if (sfrRead && sfrAddr == EVENT_FLAG_ADDR) begin
        sfrReadData <= eventFlag_q;
      end else if (sfrRead && sfrAddr == INT_STATUS_ADDR) begin
        // live levels, no latching; kick bit reads zero
        sfrReadData <= {1'b0, externalInterrupts};
      end else begin
        sfrReadData <= 8'h00;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_rise_sets;
    @(posedge clk) disable iff (reset)
      clkEnable && pllRise |=> eventFlag_q[LOCK_GAIN_BIT];
  endproperty
  a_rise_sets: assert property (p_rise_sets)
    else $error("lock gain flag not set");

  property p_fall_sets;
    @(posedge clk) disable iff (reset)
      clkEnable && pllFall |=> eventFlag_q[LOCK_LOSS_BIT];
  endproperty
  a_fall_sets: assert property (p_fall_sets)
    else $error("lock loss flag not set");

  property p_xfer_sets;
    @(posedge clk) disable iff (reset)
      clkEnable && transferBusyInterrupt |=> eventFlag_q[XFER_BIT];
  endproperty
  a_xfer_sets: assert property (p_xfer_sets)
    else $error("transfer flag not set");

  property p_rtc_sticky;
    @(posedge clk) disable iff (reset)
      eventFlag_q[RTC_BIT] && !(clkEnable && flagWrite
        && !sfrWriteData[RTC_BIT]) |=> eventFlag_q[RTC_BIT];
  endproperty
  a_rtc_sticky: assert property (p_rtc_sticky)
    else $error("rtc flag dropped without clear");

  property p_col_busy;
    @(posedge clk) disable iff (reset)
      clkEnable && flashWriteWhileBusy |=> eventFlag_q[COL_BUSY_BIT];
  endproperty
  a_col_busy: assert property (p_col_busy)
    else $error("busy collision flag not set");

  property p_col_start;
    @(posedge clk) disable iff (reset)
      clkEnable && flashWriteAtPassStart |=> eventFlag_q[COL_START_BIT];
  endproperty
  a_col_start: assert property (p_col_start)
    else $error("start collision flag not set");

  property p_pb_sets;
    @(posedge clk) disable iff (reset)
      clkEnable && pushbuttonPressed |=> eventFlag_q[PB_BIT];
  endproperty
  a_pb_sets: assert property (p_pb_sets)
    else $error("pushbutton flag not set");

  property p_wake_sets;
    @(posedge clk) disable iff (reset)
      clkEnable && autowakeTimerWake |=> eventFlag_q[WAKE_BIT];
  endproperty
  a_wake_sets: assert property (p_wake_sets)
    else $error("wake flag not set");

  property p_ones_ignored;
    @(posedge clk) disable iff (reset)
      clkEnable && flagWrite && (sfrWriteData == 8'hff)
        |=> eventFlag_q == ($past(eventFlag_q) | $past(eventSet));
  endproperty
  a_ones_ignored: assert property (p_ones_ignored)
    else $error("write of ones changed flags");

  property p_status_read;
    @(posedge clk) disable iff (reset)
      clkEnable && sfrRead && sfrAddr == INT_STATUS_ADDR
        |=> sfrReadData == {1'b0, $past(externalInterrupts)};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read not live levels");

  property p_kick;
    @(posedge clk) disable iff (reset)
      clkEnable && statusWrite && sfrWriteData[KICK_BIT]
        |=> watchdogKick;
  endproperty
  a_kick: assert property (p_kick)
    else $error("watchdog kick missing");

  property p_kick_quiet;
    @(posedge clk) disable iff (reset)
      clkEnable && !(statusWrite && sfrWriteData[KICK_BIT])
        |=> !watchdogKick;
  endproperty
  a_kick_quiet: assert property (p_kick_quiet)
    else $error("watchdog kick without write");

  property p_clear_xfer;
    @(posedge clk) disable iff (reset)
      clkEnable && flagWrite && !sfrWriteData[XFER_BIT]
        && !transferBusyInterrupt |=> !eventFlag_q[XFER_BIT];
  endproperty
  a_clear_xfer: assert property (p_clear_xfer)
    else $error("transfer flag not cleared");

  property p_clear_rtc;
    @(posedge clk) disable iff (reset)
      clkEnable && flagWrite && !sfrWriteData[RTC_BIT]
        && !rtcTick |=> !eventFlag_q[RTC_BIT];
  endproperty
  a_clear_rtc: assert property (p_clear_rtc)
    else $error("rtc flag not cleared");

  property p_clear_col_busy;
    @(posedge clk) disable iff (reset)
      clkEnable && flagWrite && !sfrWriteData[COL_BUSY_BIT]
        && !flashWriteWhileBusy |=> !eventFlag_q[COL_BUSY_BIT];
  endproperty
  a_clear_col_busy: assert property (p_clear_col_busy)
    else $error("busy collision flag not cleared");

  property p_clear_col_start;
    @(posedge clk) disable iff (reset)
      clkEnable && flagWrite && !sfrWriteData[COL_START_BIT]
        && !flashWriteAtPassStart |=> !eventFlag_q[COL_START_BIT];
  endproperty
  a_clear_col_start: assert property (p_clear_col_start)
    else $error("start collision flag not cleared");

  property p_clear_pb;
    @(posedge clk) disable iff (reset)
      clkEnable && flagWrite && !sfrWriteData[PB_BIT]
        && !pushbuttonPressed |=> !eventFlag_q[PB_BIT];
  endproperty
  a_clear_pb: assert property (p_clear_pb)
    else $error("pushbutton flag not cleared");

  property p_clear_wake;
    @(posedge clk) disable iff (reset)
      clkEnable && flagWrite && !sfrWriteData[WAKE_BIT]
        && !autowakeTimerWake |=> !eventFlag_q[WAKE_BIT];
  endproperty
  a_clear_wake: assert property (p_clear_wake)
    else $error("wake flag not cleared");

  property p_clear_rise;
    @(posedge clk) disable iff (reset)
      clkEnable && flagWrite && !sfrWriteData[LOCK_GAIN_BIT]
        && !pllRise |=> !eventFlag_q[LOCK_GAIN_BIT];
  endproperty
  a_clear_rise: assert property (p_clear_rise)
    else $error("lock gain flag not cleared");

  property p_clear_fall;
    @(posedge clk) disable iff (reset)
      clkEnable && flagWrite && !sfrWriteData[LOCK_LOSS_BIT]
        && !pllFall |=> !eventFlag_q[LOCK_LOSS_BIT];
  endproperty
  a_clear_fall: assert property (p_clear_fall)
    else $error("lock loss flag not cleared");

  property p_flag_read;
    @(posedge clk) disable iff (reset)
      clkEnable && sfrRead && sfrAddr == EVENT_FLAG_ADDR
        |=> sfrReadData == $past(eventFlag_q);
  endproperty
  a_flag_read: assert property (p_flag_read)
    else $error("flag read wrong");

  // unmapped or idle cycles must not leak stale data onto the bus
  property p_idle_zero;
    @(posedge clk) disable iff (reset)
      clkEnable && !(sfrRead && (sfrAddr == EVENT_FLAG_ADDR
        || sfrAddr == INT_STATUS_ADDR)) |=> sfrReadData == 8'h00;
  endproperty
  a_idle_zero: assert property (p_idle_zero)
    else $error("read data not zero when idle");

  property p_frozen;
    @(posedge clk) disable iff (reset)
      !clkEnable |=> $stable(eventFlag_q) && $stable(sfrReadData)
        && $stable(watchdogKick);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("state moved while disabled");
endmodule : ifsr_flag_regs
`default_nettype wire

// file: hdl/ifsr_pkg.sv
package ifsr_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] EVENT_FLAG_ADDR = 8'he8;
  localparam logic [7:0] INT_STATUS_ADDR = 8'hf8;
  localparam logic [7:0] EVENT_FLAG_RESET = 8'h00;
  // ****************************************
  // field positions
  // ****************************************
  localparam int XFER_BIT = 0;
  localparam int RTC_BIT = 1;
  localparam int COL_BUSY_BIT = 2;
  localparam int COL_START_BIT = 3;
  localparam int PB_BIT = 4;
  localparam int WAKE_BIT = 5;
  localparam int LOCK_GAIN_BIT = 6;
  localparam int LOCK_LOSS_BIT = 7;
  localparam int KICK_BIT = 7;
  localparam int EXT_INT_COUNT = 7;
  localparam int FLAG_COUNT = 8;
endpackage : ifsr_pkg

// file: testbench/ifsr_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module ifsr_cpu_model (
  input wire logic clk,
  input wire logic [7:0] rdData,
  output logic [7:0] addr,
  output logic wr,
  output logic rd,
  output logic [7:0] wdata
);
  initial begin
    addr = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
  end
  // whole-byte writes, ones except bits to clear
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
    wdata = ~d;
  endtask : put
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    d = rdData;
  endtask : get
endmodule : ifsr_cpu_model
`default_nettype wire

// file: testbench/ifsr_flag_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none
module ifsr_flag_regs_bench;
  import ifsr_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] ev = 8'h00;
  logic [6:0] ext = 7'h00;
  logic en = 1'b1;
  logic [7:0] rdData, addr, wdata, got, mask;
  logic wr, rd, kick;
  logic [7:0] expF = 8'h00;
  logic [31:0] seed = 32'h00006eb5;
  logic [31:0] r;
  int nMismatch = 0;
  int samplesChecked = 0;
  always #4 clk = ~clk;
  ifsr_cpu_model cpu (.clk(clk), .rdData(rdData), .addr(addr), .wr(wr),
    .rd(rd), .wdata(wdata));
  ifsr_flag_regs uut (.clk(clk), .reset(reset), .clkEnable(en),
    .sfrAddr(addr), .sfrWrite(wr), .sfrRead(rd), .sfrWriteData(wdata),
    .sfrReadData(rdData), .transferBusyInterrupt(ev[0]), .rtcTick(ev[1]),
    .flashWriteWhileBusy(ev[2]), .flashWriteAtPassStart(ev[3]),
    .pushbuttonPressed(ev[4]), .autowakeTimerWake(ev[5]),
    .pllRise(ev[6]), .pllFall(ev[7]), .externalInterrupts(ext),
    .watchdogKick(kick));
  function automatic logic [31:0] nxt();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : nxt
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samplesChecked++;
    if (g !== e) begin
      nMismatch++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (nMismatch == 0 && samplesChecked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // ****************
  // sequence
  // ****************
  initial begin
    #100000;
    nMismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge clk);
    #1;
    reset = 1'b0;
    cpu.get(EVENT_FLAG_ADDR, got);
    chk("flags", EVENT_FLAG_RESET, got);
    for (int i = 0; i < 60; i++) begin
      r = nxt();
      @(posedge clk);
      #1;
      ev = r[7:0] & r[15:8];
      ext = r[22:16];
      // a disabled cycle must drop the events offered in it
      en = r[23] | r[9];
      @(posedge clk);
      #1;
      expF = expF | (en ? ev : 8'h00);
      ev = 8'h00;
      en = 1'b1;
      // sparse zeros so several flags stay pending across a clear
      mask = r[31:24] | r[15:8];
      cpu.put(EVENT_FLAG_ADDR, mask);
      expF = expF & mask;
      cpu.put(8'hd8, 8'h00);
      cpu.get(EVENT_FLAG_ADDR, got);
      chk("flags", expF, got);
      cpu.get(INT_STATUS_ADDR, got);
      chk("status", {1'b0, ext}, got);
      cpu.put(INT_STATUS_ADDR, {r[8], 7'h7f});
      chk("kick", {7'h00, r[8]}, {7'h00, kick});
      cpu.get(8'hd8, got);
      chk("unmapped", 8'h00, got);
    end
    tally_and_finish();
  end
endmodule : ifsr_flag_regs_bench
`default_nettype wire
